/* hdl/nbm_core.sv */
`timescale 1ns/1ps
// ==========================================================
// Block management, internal ECC and power-up gating
module nbm_core
   import nbm_pkg::*;
#(
   parameter int unsigned STATUS_CYCLES = STATUS_CYC,  // Shorten in simulation
   parameter int unsigned FULL_CYCLES   = FULL_CYC     // Shorten in simulation
)
(
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   // Feature command port
   input  wire logic              feat_valid,
   input  wire logic [7:0]        feat_cmd,
   input  wire logic [7:0]        feat_addr,
   input  wire logic [7:0]        feat_wdata,
   output logic                   feat_rdata_valid,
   output logic [7:0]             feat_rdata,
   output logic                   ecc_enable,
   // Factory invalid-block marking
   input  wire logic              mark_valid,
   input  wire logic [BLK_W-1:0]  mark_block,
   output logic                   mark_refused,
   output logic [11:0]            valid_block_count,
   // Array read overlay
   input  wire logic              rd_valid,
   input  wire logic [BLK_W-1:0]  rd_block,
   input  wire logic [PAGE_W-1:0] rd_page,
   input  wire logic [COL_W-1:0]  rd_col,
   input  wire logic [7:0]        rd_raw,
   output logic                   rd_data_valid,
   output logic [7:0]             rd_data,
   // ECC segment stream
   input  wire logic              seg_start,
   input  wire logic              seg_check,
   input  wire logic              seg_byte_valid,
   input  wire logic [7:0]        seg_byte,
   input  wire logic [PAR_W-1:0]  seg_stored_par,
   output logic                   seg_done,
   output logic [PAR_W-1:0]       seg_parity,
   output logic                   seg_corr_valid,
   output logic [SYN_W-1:0]       seg_corr_bit,
   output logic                   seg_uncorrectable,
   // Power-up gating
   output logic                   status_read_ok,
   output logic                   full_access_ok
);

   // ==========================================================
   // Bit-position syndrome of one byte
   function automatic logic [SYN_W-1:0] byte_syn(input logic [IDX_W-1:0] idx, input logic [7:0] b);
      logic [SYN_W-1:0] acc;
      logic [SYN_W-1:0] pos;
      acc = '0;
      for (int k = 0; k < 8; k++)
      begin
         pos = SYN_W'({idx, 3'(k)}) + SYN_W'(1);  // Offset so bit 0 is visible
         if (b[k])
            acc = acc ^ pos;
      end
      return acc;
   endfunction

   // ==========================================================
   // Power-up timer
   logic [TMR_W-1:0] pu_cnt;   // Cycles since reset release
   wire              pu_stat = (pu_cnt >= TMR_W'(STATUS_CYCLES));
   wire              pu_full = (pu_cnt >= TMR_W'(FULL_CYCLES));

   // Count until fully accessible, then hold
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         pu_cnt <= '0;
      else if (!pu_full)
         pu_cnt <= pu_cnt + TMR_W'(1);
   end

   // Ready flags from flops
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         status_read_ok <= 1'b0;
         full_access_ok <= 1'b0;
      end
      else
      begin
         status_read_ok <= pu_stat;
         full_access_ok <= pu_full;
      end
   end

   // ==========================================================
   // Feature access; refused until fully accessible
   wire feat_ok  = feat_valid && full_access_ok && (feat_addr == FEAT_CFG_ADDR);
   wire feat_set = feat_ok && (feat_cmd == CMD_SET_FEAT);
   wire feat_get = feat_ok && (feat_cmd == CMD_GET_FEAT);

   // ECC enable bit, on at reset
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         ecc_enable <= ECC_E_RESET;
      else if (feat_set)
         ecc_enable <= feat_wdata[ECC_E_BIT];
   end

   // Feature read-back, one cycle after the request
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         feat_rdata_valid <= 1'b0;
         feat_rdata       <= '0;
      end
      else
      begin
         feat_rdata_valid <= feat_get;
         if (feat_get)
            feat_rdata <= 8'(ecc_enable) << ECC_E_BIT;
      end
   end

   // ==========================================================
   // Invalid-block marking and read overlay
   logic [5:0] invalid_cnt;   // Blocks marked so far
   logic       map_bit;       // Bitmap read data
   logic       rd_p1;         // Read in flight
   logic       rd_mark_loc;   // Read hits a marker byte
   logic [7:0] rd_raw_p1;     // Raw byte held one cycle

   // Block zero and overflow past the invalid budget are refused
   wire mark_bad  = (mark_block == GUARANTEED_BLK) ||
                    (invalid_cnt >= 6'(MAX_INVALID));
   wire mark_take = mark_valid && !mark_bad;
   wire mark_loc  = (rd_page <= MARK_PAGE_LAST) && (rd_col == SPARE_COL0);

   nbm_bitmap
   #(
      .DEPTH (BLOCKS),
      .AW    (BLK_W)
   )
   u_map
   (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .wr_en   (mark_take),
      .wr_addr (mark_block),
      .rd_en   (rd_valid),
      .rd_addr (rd_block),
      .rd_bit  (map_bit)
   );

   // Count marks; a repeat mark of the same block counts again, which is safe
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         invalid_cnt       <= '0;
         mark_refused      <= 1'b0;
         valid_block_count <= 12'(BLOCKS);
      end
      else
      begin
         mark_refused <= mark_valid && mark_bad;
         if (mark_take)
         begin
            invalid_cnt       <= invalid_cnt + 6'h01;
            valid_block_count <= valid_block_count - 12'h001;
         end
      end
   end

   // Read pipeline aligned with the bitmap latency
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_p1         <= 1'b0;
         rd_mark_loc   <= 1'b0;
         rd_raw_p1     <= ERASED_BYTE;
         rd_data_valid <= 1'b0;
         rd_data       <= ERASED_BYTE;
      end
      else
      begin
         rd_p1         <= rd_valid;
         rd_mark_loc   <= mark_loc;
         rd_raw_p1     <= rd_raw;
         rd_data_valid <= rd_p1;
         if (rd_p1)
            rd_data <= (map_bit && rd_mark_loc) ? INVALID_MARK : rd_raw_p1;
      end
   end

   // ==========================================================
   // ECC segment engine
   nbm_seg_state_t   st;
   nbm_seg_state_t   next_st;
   logic [IDX_W-1:0] idx;       // Byte index in segment
   logic [SYN_W-1:0] syn_acc;   // Running position syndrome
   logic             par_acc;   // Running data parity
   logic             chk;       // Segment is a read check

   wire last_byte = seg_byte_valid && (idx == IDX_W'(SEG_BYTES - 1));
   // Difference against stored parity; parity bits are not self-covered,
   // so a flip in stored syndrome bits reads as uncorrectable
   wire [SYN_W-1:0] syn_diff = syn_acc ^ seg_stored_par[SYN_W-1:0];
   wire             par_diff = par_acc ^ seg_stored_par[SYN_W];

   // State choice
   always_comb
   begin
      case (st)
         NBM_IDLE: next_st = seg_start ? NBM_RUN : NBM_IDLE;
         NBM_RUN:  next_st = last_byte ? NBM_EVAL : NBM_RUN;
         NBM_EVAL: next_st = NBM_IDLE;
         default:  next_st = NBM_IDLE;
      endcase
   end

   // State and accumulators
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st      <= NBM_IDLE;
         idx     <= '0;
         syn_acc <= '0;
         par_acc <= 1'b0;
         chk     <= 1'b0;
      end
      else
      begin
         st <= next_st;
         if (st == NBM_IDLE && seg_start)
         begin
            idx     <= '0;
            syn_acc <= '0;
            par_acc <= 1'b0;
            chk     <= seg_check;
         end
         else if (st == NBM_RUN && seg_byte_valid)
         begin
            idx     <= idx + IDX_W'(1);
            syn_acc <= syn_acc ^ byte_syn(idx, seg_byte);
            par_acc <= par_acc ^ (^seg_byte);
         end
      end
   end

   // Verdict two cycles after the 528th byte
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         seg_done          <= 1'b0;
         seg_parity        <= '0;
         seg_corr_valid    <= 1'b0;
         seg_corr_bit      <= '0;
         seg_uncorrectable <= 1'b0;
      end
      else
      begin
         seg_done       <= (st == NBM_EVAL);
         seg_corr_valid <= 1'b0;
         if (st == NBM_IDLE && seg_start)
            seg_uncorrectable <= 1'b0;
         if (st == NBM_EVAL)
         begin
            seg_parity <= {par_acc, syn_acc};
            // Checking only with ECC enabled
            if (chk && ecc_enable)
            begin
               if (par_diff)
               begin
                  seg_corr_valid <= (syn_diff != '0);
                  seg_corr_bit   <= syn_diff - SYN_W'(1);
               end
               else if (syn_diff != '0)
                  seg_uncorrectable <= 1'b1;
            end
         end
      end
   end

endmodule

/* hdl/nbm_pkg.sv */
package nbm_pkg;

   // ==========================================================
   // Array geometry
   localparam int unsigned BLOCKS          = 2048;     // Blocks in the array
   localparam int unsigned MIN_VALID       = 2008;     // Least usable blocks
   localparam int unsigned MAX_INVALID     = BLOCKS - MIN_VALID;
   localparam int unsigned BLK_W           = 11;       // Block address width
   localparam int unsigned PAGE_W          = 6;        // Page-in-block width
   localparam int unsigned COL_W           = 12;       // Column width
   localparam logic [11:0] SPARE_COL0      = 12'h800;  // First spare byte
   localparam logic [5:0]  MARK_PAGE_LAST  = 6'h01;    // Marks on page 0 or 1
   localparam logic [7:0]  ERASED_BYTE     = 8'hff;    // Erased content
   localparam logic [7:0]  INVALID_MARK    = 8'h00;    // Factory invalid mark
   localparam logic [10:0] GUARANTEED_BLK  = 11'h000;  // Always-valid block

   // ==========================================================
   // ECC segment
   localparam int unsigned SEG_MAIN        = 512;      // Main bytes
   localparam int unsigned SEG_SPARE       = 16;       // Spare bytes
   localparam int unsigned SEG_BYTES       = SEG_MAIN + SEG_SPARE;
   localparam int unsigned IDX_W           = 10;       // Byte index width
   localparam int unsigned SYN_W           = 13;       // Bit position width
   localparam int unsigned PAR_W           = SYN_W + 1;

   // ==========================================================
   // Feature commands
   localparam logic [7:0]  CMD_SET_FEAT    = 8'h1f;    // Feature write
   localparam logic [7:0]  CMD_GET_FEAT    = 8'h0f;    // Feature read
   localparam logic [7:0]  FEAT_CFG_ADDR   = 8'hb0;    // Configuration feature
   localparam int unsigned ECC_E_BIT       = 4;        // ECC enable position
   localparam logic        ECC_E_RESET     = 1'b1;     // Enabled at power-up

   // ==========================================================
   // Power-up timing
   localparam int unsigned CLK_MHZ         = 200;      // ref_clk rate
   localparam int unsigned STATUS_DELAY_US = 200;      // supply_to_status_read_delay
   localparam int unsigned FULL_DELAY_MS   = 1;        // supply_to_full_access_delay
   localparam int unsigned STATUS_CYC      = STATUS_DELAY_US * CLK_MHZ;
   localparam int unsigned FULL_CYC        = FULL_DELAY_MS * 1000 * CLK_MHZ;
   localparam int unsigned TMR_W           = 18;       // Power-up counter width

   // Segment engine states, Gray from IDLE through RUN to EVAL; EVAL back to IDLE flips both bits
   typedef enum logic [1:0]
   {
      NBM_IDLE = 2'b00,
      NBM_RUN  = 2'b01,
      NBM_EVAL = 2'b11
   } nbm_seg_state_t;

endpackage

/* hdl/nbm_bitmap.sv */
`timescale 1ns/1ps
// ==========================================================
// Invalid-block bitmap, one bit per block, registered read
module nbm_bitmap
#(
   parameter int unsigned DEPTH = 2048,
   parameter int unsigned AW    = 11
)
(
   input  wire logic          ref_clk,
   input  wire logic          rst_b,
   input  wire logic          wr_en,    // Write strobe
   input  wire logic [AW-1:0] wr_addr,  // Write block
   input  wire logic          rd_en,    // Read strobe
   input  wire logic [AW-1:0] rd_addr,  // Read block
   output logic               rd_bit    // Registered read bit
);

   logic [DEPTH-1:0] map;   // Set means invalid; cleared by reset

   // Storage; cleared at reset so the shipped array starts all valid
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         map <= '0;
      else if (wr_en)
         map[wr_addr] <= 1'b1;
   end

   // Read register
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         rd_bit <= 1'b0;
      else if (rd_en)
         rd_bit <= map[rd_addr];
   end

endmodule

/* dv/nbm_array_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Array cells behind the read overlay
module nbm_array_model
   import nbm_pkg::*;
(
   input  wire logic [BLK_W-1:0] rd_block,  // Addressed block
   input  wire logic [COL_W-1:0] rd_col,    // Addressed column
   output logic      [7:0]       rd_raw     // Raw cell byte
);
   // Upper half programmed, so a stuck overlay cannot hide as FFh
   assign rd_raw = rd_block[10] ? rd_col[7:0] : ERASED_BYTE;
endmodule

/* dv/nbm_core_asserts.sv */
`timescale 1ns/1ps
// ==========================================================
// Port checks on the core
module nbm_core_asserts
   import nbm_pkg::*;
(
   input wire logic             ref_clk,
   input wire logic             rst_b,
   input wire logic             feat_valid,
   input wire logic [7:0]       feat_cmd,
   input wire logic [7:0]       feat_addr,
   input wire logic [7:0]       feat_wdata,
   input wire logic             feat_rdata_valid,
   input wire logic [7:0]       feat_rdata,
   input wire logic             ecc_enable,
   input wire logic             mark_valid,
   input wire logic [BLK_W-1:0] mark_block,
   input wire logic             mark_refused,
   input wire logic [11:0]      valid_block_count,
   input wire logic             rd_valid,
   input wire logic [COL_W-1:0] rd_col,
   input wire logic [7:0]       rd_raw,
   input wire logic             rd_data_valid,
   input wire logic [7:0]       rd_data,
   input wire logic             seg_done,
   input wire logic             seg_corr_valid,
   input wire logic             seg_uncorrectable,
   input wire logic             status_read_ok,
   input wire logic             full_access_ok
);
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // ==========================================================
   // Accepted configuration access
   logic cfg_hit;  // Addressed and past power-up
   assign cfg_hit = feat_valid && full_access_ok && feat_addr == FEAT_CFG_ADDR;

   reset_state_a: assert property ($rose(rst_b) |-> ecc_enable && valid_block_count == 12'h800)
      else $error("reset state wrong");
   block_zero_a: assert property (mark_valid && mark_block == GUARANTEED_BLK |=> mark_refused && $stable(valid_block_count))
      else $error("block zero mark not refused");
   count_range_a: assert property (valid_block_count >= 12'h7d8 && valid_block_count <= 12'h800)
      else $error("usable block count out of range");
   mark_count_a: assert property (mark_valid && mark_block != GUARANTEED_BLK && valid_block_count > 12'h7d8
      |=> !mark_refused && valid_block_count == $past(valid_block_count) - 12'h001)
      else $error("accepted mark not counted");
   read_pass_a: assert property (rd_valid && rd_col != SPARE_COL0 |-> ##2 rd_data_valid && rd_data == $past(rd_raw, 2))
      else $error("read byte altered");
   ecc_set_a: assert property (cfg_hit && feat_cmd == CMD_SET_FEAT |=> ecc_enable == $past(feat_wdata[4]))
      else $error("ecc enable not set from data");
   ecc_get_a: assert property (cfg_hit && feat_cmd == CMD_GET_FEAT |=> feat_rdata_valid && feat_rdata == {3'h0, $past(ecc_enable), 4'h0})
      else $error("feature read wrong");
   early_feat_a: assert property (feat_valid && !full_access_ok |=> !feat_rdata_valid && $stable(ecc_enable))
      else $error("feature taken too early");
   verdict_gate_a: assert property (seg_corr_valid || $rose(seg_uncorrectable) |-> seg_done && $past(ecc_enable))
      else $error("verdict outside an enabled check");
   power_order_a: assert property (full_access_ok |-> status_read_ok)
      else $error("full access before status access");
endmodule

bind nbm_core nbm_core_asserts chk_u (.ref_clk, .rst_b, .feat_valid, .feat_cmd, .feat_addr, .feat_wdata,
   .feat_rdata_valid, .feat_rdata, .ecc_enable, .mark_valid, .mark_block, .mark_refused, .valid_block_count,
   .rd_valid, .rd_col, .rd_raw, .rd_data_valid, .rd_data, .seg_done, .seg_corr_valid, .seg_uncorrectable,
   .status_read_ok, .full_access_ok);

/* dv/nbm_core_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the core
module nbm_core_tb
   import nbm_pkg::*;
();
   logic              ref_clk = 1'b0, rst_b = 1'b0;
   logic              feat_valid = 1'b0, mark_valid = 1'b0, rd_valid = 1'b0;
   logic              seg_start = 1'b0, seg_check = 1'b0, seg_byte_valid = 1'b0;
   logic [7:0]        feat_cmd = 8'h00, feat_addr = 8'h00, feat_wdata = 8'h00, seg_byte = 8'h00;
   logic [BLK_W-1:0]  mark_block = 11'h000, rd_block = 11'h000;
   logic [PAGE_W-1:0] rd_page = 6'h00;
   logic [COL_W-1:0]  rd_col = 12'h000;
   logic [PAR_W-1:0]  seg_stored_par = 14'h0000, seg_parity;
   logic [7:0]        rd_raw, feat_rdata, rd_data;
   logic              feat_rdata_valid, ecc_enable, mark_refused, rd_data_valid, seg_done;
   logic              seg_corr_valid, seg_uncorrectable, status_read_ok, full_access_ok;
   logic [11:0]       valid_block_count;
   logic [SYN_W-1:0]  seg_corr_bit;
   int                num_errors = 0, comparisons = 0, cyc = 0;

   // Short power-up counts: 40 and 100 cycles
   nbm_core #(.STATUS_CYCLES(40), .FULL_CYCLES(100)) dut_u
   (
      .ref_clk, .rst_b, .feat_valid, .feat_cmd, .feat_addr, .feat_wdata, .feat_rdata_valid,
      .feat_rdata, .ecc_enable, .mark_valid, .mark_block, .mark_refused, .valid_block_count,
      .rd_valid, .rd_block, .rd_page, .rd_col, .rd_raw, .rd_data_valid, .rd_data, .seg_start,
      .seg_check, .seg_byte_valid, .seg_byte, .seg_stored_par, .seg_done, .seg_parity,
      .seg_corr_valid, .seg_corr_bit, .seg_uncorrectable, .status_read_ok, .full_access_ok
   );
   nbm_array_model array_u (.rd_block, .rd_col, .rd_raw);

   // ==========================================================
   // Clock and cycles since reset release
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= rst_b ? cyc + 1 : 0;

   // ==========================================================
   // Shared helpers
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Wait for a cycle count; margins allow for the counter phase
   task automatic upto(input int n);
      while (cyc < n)
         @(posedge ref_clk);
      #1;
   endtask

   // One feature request; ends where the answer is visible
   task automatic feat(input logic [7:0] cmd, input logic [7:0] addr, input logic [7:0] wd);
      @(posedge ref_clk);
      feat_valid <= 1'b1;
      feat_cmd <= cmd;
      feat_addr <= addr;
      feat_wdata <= wd;
      @(posedge ref_clk);
      feat_valid <= 1'b0;
      #1;
   endtask

   task automatic mark(input logic [10:0] blk);
      @(posedge ref_clk);
      mark_valid <= 1'b1;
      mark_block <= blk;
      @(posedge ref_clk);
      mark_valid <= 1'b0;
      #1;
   endtask

   // Read answers exactly two cycles after the request
   task automatic rd(input logic [10:0] b, input logic [5:0] p, input logic [11:0] c, input logic [7:0] exp);
      @(posedge ref_clk);
      rd_valid <= 1'b1;
      rd_block <= b;
      rd_page <= p;
      rd_col <= c;
      @(posedge ref_clk);
      rd_valid <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk("rd_data_valid", 16'h1, rd_data_valid);
      chk("rd_data", exp, rd_data);
   endtask

   // Whole 528-byte segment in one go; e1, e2 are set bit indices
   task automatic seg(input logic chk_mode, input int e1, input int e2, input logic [13:0] stored);
      int i;
      @(posedge ref_clk);
      seg_start <= 1'b1;
      seg_check <= chk_mode;
      seg_stored_par <= stored;
      for (i = 0; i < 528; i++)
      begin
         @(posedge ref_clk);
         seg_start <= 1'b0;
         seg_byte_valid <= 1'b1;
         seg_byte <= ((i == e1 / 8) ? 8'h01 << (e1 % 8) : 8'h00) | ((i == e2 / 8) ? 8'h01 << (e2 % 8) : 8'h00);
      end
      @(posedge ref_clk);
      seg_byte_valid <= 1'b0;
      for (i = 0; i < 6 && seg_done !== 1'b1; i++)
      begin
         @(posedge ref_clk);
         #1;
      end
      chk("seg_done", 16'h1, seg_done);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_power();
      @(posedge ref_clk);
      #1;
      chk("ecc_enable", 16'h1, ecc_enable);
      chk("valid_block_count", 16'h800, valid_block_count);
      upto(36);
      chk("status_read_ok", 16'h0, status_read_ok);
      upto(44);
      chk("status_read_ok", 16'h1, status_read_ok);
      chk("full_access_ok", 16'h0, full_access_ok);
      feat(CMD_SET_FEAT, FEAT_CFG_ADDR, 8'h00);
      chk("ecc_enable", 16'h1, ecc_enable);
      upto(104);
      chk("full_access_ok", 16'h1, full_access_ok);
   endtask

   task automatic t_marks();
      int b;
      mark(11'h000);
      chk("mark_refused", 16'h1, mark_refused);
      mark(11'h005);
      chk("valid_block_count", 16'h7ff, valid_block_count);
      // Host scans the marker bytes of pages 0 and 1 to build its table
      rd(11'h005, 6'h00, 12'h800, 8'h00);
      rd(11'h005, 6'h01, 12'h800, 8'h00);
      // Other pages and columns of a retired block, and unmarked blocks, stay untouched
      rd(11'h005, 6'h02, 12'h800, 8'hff);
      rd(11'h005, 6'h00, 12'h801, 8'hff);
      rd(11'h000, 6'h00, 12'h800, 8'hff);
      rd(11'h406, 6'h00, 12'h045, 8'h45);
      // Copy target in the same upper half reads like its source
      rd(11'h407, 6'h00, 12'h045, 8'h45);
      // Spare block picked for remapping is still valid
      rd(11'h006, 6'h00, 12'h800, 8'hff);
      for (b = 6; b < 45; b++)
         mark(b[10:0]);
      chk("valid_block_count", 16'h7d8, valid_block_count);
      mark(11'h02d);
      chk("mark_refused", 16'h1, mark_refused);
      chk("valid_block_count", 16'h7d8, valid_block_count);
   endtask

   task automatic t_feature();
      feat(CMD_SET_FEAT, FEAT_CFG_ADDR, 8'h00);
      chk("ecc_enable", 16'h0, ecc_enable);
      feat(CMD_GET_FEAT, FEAT_CFG_ADDR, 8'h00);
      chk("feat_rdata", 16'h00, feat_rdata);
      feat(CMD_SET_FEAT, FEAT_CFG_ADDR, 8'h10);
      feat(CMD_GET_FEAT, FEAT_CFG_ADDR, 8'h00);
      chk("feat_rdata_valid", 16'h1, feat_rdata_valid);
      chk("feat_rdata", 16'h10, feat_rdata);
      feat(CMD_SET_FEAT, 8'ha0, 8'h00);
      feat(8'h55, FEAT_CFG_ADDR, 8'h00);
      chk("ecc_enable", 16'h1, ecc_enable);
   endtask

   task automatic t_segment();
      seg(1'b0, 0, 9999, 14'h0000);
      chk("seg_parity", 16'h2001, seg_parity);
      // Next page of the block, programmed after the first
      seg(1'b0, 8, 9999, 14'h0000);
      chk("seg_parity", 16'h2009, seg_parity);
      // Single flip is recovered by correction, not by retiring
      seg(1'b1, 26, 9999, 14'h0000);
      chk("seg_corr_valid", 16'h1, seg_corr_valid);
      chk("seg_corr_bit", 16'h1a, seg_corr_bit);
      seg(1'b1, 26, 1, 14'h0000);
      chk("seg_uncorrectable", 16'h1, seg_uncorrectable);
      chk("seg_corr_valid", 16'h0, seg_corr_valid);
      seg(1'b1, 26, 9999, 14'h201b);
      chk("seg_uncorrectable", 16'h0, seg_uncorrectable);
      feat(CMD_SET_FEAT, FEAT_CFG_ADDR, 8'h00);
      seg(1'b1, 26, 1, 14'h0000);
      chk("seg_uncorrectable", 16'h0, seg_uncorrectable);
   endtask

   task automatic final_report();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_power();
      t_marks();
      t_feature();
      t_segment();
      final_report();
   end

   initial
   begin
      #100000;
      num_errors++;
      final_report();
   end
endmodule
